// [hw/pdr_group.sv]
// pdr_group: live direction and output latches of one A/B/C group plus their retained copy
// assumes: straps already synchronised; rst_n also asserted whenever por_n is
`timescale 1ns/1ps
`default_nettype none
module pdr_group (
  input  wire logic               hclk,
  input  wire logic               rst_n,
  input  wire logic               por_n,
  input  wire pdr_pkg::pdr_strap_t strap_s,
  input  wire logic               retain_eff,
  input  wire logic               restore,
  input  wire logic               run,
  input  wire logic               cfg_we,
  input  wire logic [2:0]         data_we,
  input  wire logic [7:0]         wdata,
  input  wire pdr_pkg::pdr_lines_t pin_in,
  output var  pdr_pkg::pdr_lines_t pin_out,
  output var  pdr_pkg::pdr_lines_t pin_oe_n,
  output var  pdr_pkg::pdr_lines_t pin_rd,
  output var  logic [3:0]         dir,
  output var  logic [3:0]         sh_dir,
  output var  pdr_pkg::pdr_lines_t sh_out
);
  logic [3:0]          dir_r, dir_nxt, sh_dir_r, sh_dir_nxt;
  pdr_pkg::pdr_lines_t out_r, out_nxt, sh_out_r, sh_out_nxt;
  pdr_pkg::pdr_lines_t s1_r, s2_r;
  logic [3:0]          strap_v;

  assign strap_v = strap_s;

  always_comb begin
    dir_nxt = dir_r;
    out_nxt = out_r;
    if (restore) begin
      // retain_eff picks the shadow after a retained hot reset and the defaults otherwise, power-on included
      dir_nxt = retain_eff ? sh_dir_r : pdr_pkg::DIR_RST;
      out_nxt = retain_eff ? sh_out_r : pdr_pkg::OUT_RST;
    end else begin
      if (cfg_we) begin
        dir_nxt[pdr_pkg::DIR_A]  = wdata[pdr_pkg::CW_PORTA_BIT];
        dir_nxt[pdr_pkg::DIR_B]  = wdata[pdr_pkg::CW_PORTB_BIT];
        dir_nxt[pdr_pkg::DIR_CL] = wdata[pdr_pkg::CW_CLO_BIT];
        dir_nxt[pdr_pkg::DIR_CH] = wdata[pdr_pkg::CW_CHI_BIT];
      end
      if (data_we[pdr_pkg::PORTA_IDX]) out_nxt.porta_line = wdata;
      if (data_we[pdr_pkg::PORTB_IDX]) out_nxt.portb_line = wdata;
      if (data_we[pdr_pkg::PORTC_IDX]) out_nxt.portc_line = wdata;
    end
    dir_nxt = dir_nxt & ~strap_v;
  end

  // shadow follows the live state only while running, so it keeps the last pre-reset value
  always_comb begin
    sh_dir_nxt = run ? dir_r : sh_dir_r;
    sh_out_nxt = run ? out_r : sh_out_r;
  end

  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      dir_r <= pdr_pkg::DIR_RST;
      out_r <= pdr_pkg::OUT_RST;
      s1_r  <= pdr_pkg::OUT_RST;
      s2_r  <= pdr_pkg::OUT_RST;
    end else begin
      dir_r <= dir_nxt;
      out_r <= out_nxt;
      s1_r  <= pin_in;
      s2_r  <= s1_r;
    end
  end

  // only power loss clears the retained copy
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      sh_dir_r <= pdr_pkg::DIR_RST;
      sh_out_r <= pdr_pkg::OUT_RST;
    end else begin
      sh_dir_r <= sh_dir_nxt;
      sh_out_r <= sh_out_nxt;
    end
  end

  // line n of each port is bit n of its byte
  assign pin_out  = out_r;
  assign pin_oe_n = {{4{dir_r[pdr_pkg::DIR_CH]}}, {4{dir_r[pdr_pkg::DIR_CL]}},
                     {8{dir_r[pdr_pkg::DIR_B]}}, {8{dir_r[pdr_pkg::DIR_A]}}};

  // inputs read the pins, outputs read back their latch
  always_comb begin
    pin_rd = out_r;
    if (dir_r[pdr_pkg::DIR_A])  pin_rd.porta_line = s2_r.porta_line;
    if (dir_r[pdr_pkg::DIR_B])  pin_rd.portb_line = s2_r.portb_line;
    if (dir_r[pdr_pkg::DIR_CL]) pin_rd.portc_line[3:0] = s2_r.portc_line[3:0];
    if (dir_r[pdr_pkg::DIR_CH]) pin_rd.portc_line[7:4] = s2_r.portc_line[7:4];
  end

  assign dir    = dir_r;
  assign sh_dir = sh_dir_r;
  assign sh_out = sh_out_r;

endmodule : pdr_group
`default_nettype wire

// [hw/pdr_pkg.sv]
// pdr_pkg: constants and carrier types for the port direction / reset retention block
// assumes: one card clock, twelve 8-bit ports grouped as four groups of A, B and C
package pdr_pkg;

  // register indices; byte address is four times the index
  localparam logic [1:0] PORTA_IDX  = 2'h0;
  localparam logic [1:0] PORTB_IDX  = 2'h1;
  localparam logic [1:0] PORTC_IDX  = 2'h2;
  localparam logic [1:0] CFG_IDX    = 2'h3;
  localparam logic [5:0] STATUS_IDX = 6'h10;

  // control word bit positions, 0 selects output and 1 selects input
  localparam int CW_PORTA_BIT = 4;
  localparam int CW_CHI_BIT   = 3;
  localparam int CW_PORTB_BIT = 1;
  localparam int CW_CLO_BIT   = 0;

  // bit positions inside a group's direction vector and strap struct
  localparam int DIR_A  = 0;
  localparam int DIR_B  = 1;
  localparam int DIR_CL = 2;
  localparam int DIR_CH = 3;

  // status register fields
  localparam int STAT_RETAIN_BIT = 16;
  localparam int STAT_HOT_BIT    = 17;

  // reset values
  localparam logic [3:0]  DIR_RST = 4'hf;
  localparam logic [23:0] OUT_RST = 24'h00_0000;

  // edges after reset release before the restore step, lets straps settle
  localparam logic [1:0] SETTLE_CNT = 2'h3;

  typedef struct packed {
    logic portc_high_nibble_strap;
    logic portc_low_nibble_strap;
    logic portb_dir_strap;
    logic porta_dir_strap;
  } pdr_strap_t;

  typedef struct packed {
    logic [7:0] portc_line;
    logic [7:0] portb_line;
    logic [7:0] porta_line;
  } pdr_lines_t;

  typedef struct packed {
    logic [5:0] idx;
    logic       write;
  } pdr_req_t;

  typedef enum logic [0:0] {
    PDR_PH_IDLE = 1'b0,
    PDR_PH_DATA = 1'b1
  } pdr_phase_t;

endpackage : pdr_pkg

// [hw/pdr_port_ctl.sv]
// pdr_port_ctl: strap-driven direction and reset retention for twelve 8-bit ports, AHB-Lite slave
// assumes: por_n low only on power-up and always with hresetn; straps and lines are async pins
//
// Overview of operation
// - closed direction strap forces its port or nibble to output, software cannot override.
// - open direction strap leaves port direction to software.
// - without retention, software ports become inputs after reset, pins reading high.
// - strap-forced ports drive low after reset unless retention restores a value.
// - with retention, direction and output values before a hot reset are restored.
// - retention covers software ports and strap-forced ports alike.
// - power loss clears retained state; power-on always gives defaults.
// - each port has eight lines 0 to 7, line index is bit index.
// - control word direction bit is ignored for strap-forced ports.
`timescale 1ns/1ps
`default_nettype none
module pdr_port_ctl (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    por_n,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic [31:0]                  hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire logic                    reset_retain_strap,
  input  wire pdr_pkg::pdr_strap_t [3:0] dir_strap,
  input  wire pdr_pkg::pdr_lines_t [3:0] line_in,
  output var  pdr_pkg::pdr_lines_t [3:0] line_out,
  output var  pdr_pkg::pdr_lines_t [3:0] line_oe_n
);
  logic                          rst_n;
  logic [16:0]                   st1_r, st2_r;
  pdr_pkg::pdr_strap_t [3:0]     strap_s;
  logic                          retain_s;
  logic [1:0]                    cnt_r, cnt_nxt;
  logic                          hot_r, hot_nxt, restored_r, restored_nxt;
  logic                          restore, run, retain_eff;
  pdr_pkg::pdr_phase_t           ph_r, ph_nxt;
  pdr_pkg::pdr_req_t             req_r, req_nxt;
  logic [31:0]                   hrdata_r, hrdata_nxt, rdata;
  logic                          hreadyout_r, hreadyout_nxt;
  logic                          accept, wr;
  logic [3:0]                    cfg_we;
  logic [2:0]                    data_we [4];
  pdr_pkg::pdr_lines_t           pin_rd_w [4];
  pdr_pkg::pdr_lines_t           sh_out_w [4];
  logic [3:0]                    dir_w [4];
  logic [3:0]                    sh_dir_w [4];

  // hot reset also covers power-on so the live latches clear on either
  assign rst_n = hresetn & por_n;

  // strap synchronisers run from power-on only so they stay valid through a hot reset
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      st1_r <= 17'h0_0000;
      st2_r <= 17'h0_0000;
    end else begin
      st1_r <= {reset_retain_strap, dir_strap};
      st2_r <= st1_r;
    end
  end
  assign strap_s  = st2_r[15:0];
  assign retain_s = st2_r[16];

  // settle count: restore fires once, after the synchronisers have filled
  always_comb begin
    cnt_nxt = (cnt_r != 2'h0) ? cnt_r - 2'h1 : cnt_r;
  end
  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= pdr_pkg::SETTLE_CNT;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  assign restore = (cnt_r == 2'h1);
  assign run     = (cnt_r == 2'h0);

  // hot_r is set once the shadow holds real state; only power-on clears it
  assign retain_eff = retain_s & hot_r;
  always_comb begin
    hot_nxt      = hot_r | run;
    restored_nxt = restore ? retain_eff : restored_r;
  end
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      hot_r      <= 1'b0;
      restored_r <= 1'b0;
    end else begin
      hot_r      <= hot_nxt;
      restored_r <= restored_nxt;
    end
  end

  // bus: address phase captured, one data phase with a wait state, read data registered
  assign accept = hsel & hready & htrans[1];
  assign wr     = (ph_r == pdr_pkg::PDR_PH_DATA) & run & req_r.write;

  always_comb begin
    ph_nxt        = ph_r;
    req_nxt       = req_r;
    hrdata_nxt    = hrdata_r;
    hreadyout_nxt = hreadyout_r;
    unique case (ph_r)
      pdr_pkg::PDR_PH_IDLE: begin
        if (accept) begin
          ph_nxt        = pdr_pkg::PDR_PH_DATA;
          req_nxt.idx   = haddr[7:2];
          req_nxt.write = hwrite;
          hreadyout_nxt = 1'b0;
        end
      end
      pdr_pkg::PDR_PH_DATA: begin
        // held off until restore has run so a write cannot be overwritten by it
        if (run) begin
          ph_nxt        = pdr_pkg::PDR_PH_IDLE;
          hrdata_nxt    = req_r.write ? 32'h0000_0000 : rdata;
          hreadyout_nxt = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      ph_r        <= pdr_pkg::PDR_PH_IDLE;
      req_r       <= '0;
      hrdata_r    <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
    end else begin
      ph_r        <= ph_nxt;
      req_r       <= req_nxt;
      hrdata_r    <= hrdata_nxt;
      hreadyout_r <= hreadyout_nxt;
    end
  end
  assign hrdata    = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp     = 1'b0;

  // read mux; unmapped indices read zero
  always_comb begin
    rdata = 32'h0000_0000;
    if (req_r.idx[5:4] == 2'h0) begin
      unique case (req_r.idx[1:0])
        pdr_pkg::PORTA_IDX: rdata[7:0] = pin_rd_w[req_r.idx[3:2]].porta_line;
        pdr_pkg::PORTB_IDX: rdata[7:0] = pin_rd_w[req_r.idx[3:2]].portb_line;
        pdr_pkg::PORTC_IDX: rdata[7:0] = pin_rd_w[req_r.idx[3:2]].portc_line;
        pdr_pkg::CFG_IDX: begin
          rdata[pdr_pkg::CW_PORTA_BIT] = dir_w[req_r.idx[3:2]][pdr_pkg::DIR_A];
          rdata[pdr_pkg::CW_PORTB_BIT] = dir_w[req_r.idx[3:2]][pdr_pkg::DIR_B];
          rdata[pdr_pkg::CW_CLO_BIT]   = dir_w[req_r.idx[3:2]][pdr_pkg::DIR_CL];
          rdata[pdr_pkg::CW_CHI_BIT]   = dir_w[req_r.idx[3:2]][pdr_pkg::DIR_CH];
        end
      endcase
    end else if (req_r.idx == pdr_pkg::STATUS_IDX) begin
      rdata[15:0]                     = strap_s;
      rdata[pdr_pkg::STAT_RETAIN_BIT] = retain_s;
      rdata[pdr_pkg::STAT_HOT_BIT]    = restored_r;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_grp
    always_comb begin
      cfg_we[g]  = wr & (req_r.idx[5:2] == g[3:0]) & (req_r.idx[1:0] == pdr_pkg::CFG_IDX);
      data_we[g] = 3'h0;
      if (wr && (req_r.idx[5:2] == g[3:0]) && (req_r.idx[1:0] != pdr_pkg::CFG_IDX)) begin
        data_we[g][req_r.idx[1:0]] = 1'b1;
      end
    end
    pdr_group u_grp (
      .hclk       (hclk),
      .rst_n      (rst_n),
      .por_n      (por_n),
      .strap_s    (strap_s[g]),
      .retain_eff (retain_eff),
      .restore    (restore),
      .run        (run),
      .cfg_we     (cfg_we[g]),
      .data_we    (data_we[g]),
      .wdata      (hwdata[7:0]),
      .pin_in     (line_in[g]),
      .pin_out    (line_out[g]),
      .pin_oe_n   (line_oe_n[g]),
      .pin_rd     (pin_rd_w[g]),
      .dir        (dir_w[g]),
      .sh_dir     (sh_dir_w[g]),
      .sh_out     (sh_out_w[g])
    );
  end

  // checks pick the groups whose straps the bench closes or leaves open
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!rst_n);

  sequence s_restore_plain;
    restore && !retain_eff;
  endsequence
  sequence s_restore_kept;
    restore && retain_eff;
  endsequence
  sequence s_cfg0_write;
    wr && (req_r.idx == 6'h03);
  endsequence
  sequence s_power_restore;
    restore && !hot_r;
  endsequence

  a_strap_forces_out: assert property (
    run && strap_s[1].porta_dir_strap && $past(strap_s[1].porta_dir_strap)
      |-> line_oe_n[1].porta_line == 8'h00)
    else $error("strapped port A1 not driving");

  a_cfg_sets_dir: assert property (
    s_cfg0_write ##0 !strap_s[0].portb_dir_strap
      |=> line_oe_n[0].portb_line == {8{$past(hwdata[pdr_pkg::CW_PORTB_BIT])}})
    else $error("control word did not set port B0 direction");

  a_cfg_ignored: assert property (
    wr && (req_r.idx == 6'h07) && strap_s[1].porta_dir_strap ##1 strap_s[1].porta_dir_strap
      |-> !dir_w[1][pdr_pkg::DIR_A])
    else $error("control word released strapped port A1");

  a_default_input: assert property (
    s_restore_plain |=> dir_w[0] == (pdr_pkg::DIR_RST & ~$past(strap_s[0])))
    else $error("default direction wrong after plain reset");

  a_strap_low: assert property (
    s_restore_plain |=> (line_out[0] == pdr_pkg::OUT_RST) && (line_out[3] == pdr_pkg::OUT_RST))
    else $error("outputs not low after plain reset");

  a_retain_dir: assert property (
    s_restore_kept |=> dir_w[0] == ($past(sh_dir_w[0]) & ~$past(strap_s[0])))
    else $error("direction not restored after hot reset");

  a_retain_out: assert property (
    s_restore_kept |=> line_out[3] == $past(sh_out_w[3]))
    else $error("output value not restored after hot reset");

  a_por_clean: assert property (
    restore && !hot_r |=> !restored_r && line_out[1] == pdr_pkg::OUT_RST)
    else $error("power-on restored stale state");

  a_hot_only: assert property (
    $rose(restored_r) |-> $past(hot_r) && $past(retain_s) && $past(restore))
    else $error("retained state restored without hot reset");

  a_line_map: assert property (
    wr && (req_r.idx == 6'h01) |=> line_out[0].portb_line == $past(hwdata[7:0]))
    else $error("port B0 lines do not follow written byte");

  a_bus_answer: assert property (
    accept && (ph_r == pdr_pkg::PDR_PH_IDLE) && run |=> !hreadyout ##1 hreadyout)
    else $error("bus answer not after one wait state");

  a_strap_nibble: assert property (
    run && $past(strap_s[2].portc_low_nibble_strap) |-> line_oe_n[2].portc_line[3:0] == 4'h0)
    else $error("strapped port C2 low nibble not driving");

  a_strap_port_b: assert property (
    run && $past(strap_s[3].portb_dir_strap) |-> line_oe_n[3].portb_line == 8'h00)
    else $error("strapped port B3 not driving");

  a_cfg_nibble: assert property (
    wr && (req_r.idx == 6'h0b) && !strap_s[2].portc_high_nibble_strap
      |=> line_oe_n[2].portc_line[7:4] == {4{$past(hwdata[pdr_pkg::CW_CHI_BIT])}})
    else $error("control word did not set port C2 high nibble direction");

  a_default_far: assert property (
    s_restore_plain |=> dir_w[3] == (pdr_pkg::DIR_RST & ~$past(strap_s[3])))
    else $error("group 3 default direction wrong after plain reset");

  a_power_dir: assert property (
    s_power_restore |=> dir_w[2] == (pdr_pkg::DIR_RST & ~$past(strap_s[2])))
    else $error("power-on direction not default");

  a_retain_out_a: assert property (
    s_restore_kept |=> line_out[0] == $past(sh_out_w[0]))
    else $error("group 0 outputs not restored after hot reset");

  a_retain_strapped: assert property (
    s_restore_kept |=> dir_w[3] == ($past(sh_dir_w[3]) & ~$past(strap_s[3])))
    else $error("group 3 direction not restored after hot reset");

  a_shadow_track: assert property (
    $past(run) |-> sh_dir_w[1] == $past(dir_w[1]) && sh_out_w[1] == $past(line_out[1]))
    else $error("retained copy does not follow live state");

  a_shadow_frozen: assert property (
    !$past(run) |-> $stable(sh_out_w[1]) && $stable(sh_dir_w[1]))
    else $error("retained copy changed while not running");

  a_data_hold: assert property (
    (ph_r == pdr_pkg::PDR_PH_DATA) && !run |=> (ph_r == pdr_pkg::PDR_PH_DATA) && !hreadyout)
    else $error("data phase ended before restore");

  a_write_done: assert property (
    wr |=> hreadyout && (ph_r == pdr_pkg::PDR_PH_IDLE))
    else $error("write did not complete the transfer");

endmodule : pdr_port_ctl
`default_nettype wire

// [verification/pdr_field_model.sv]
// pdr_field_model: field wiring on the twelve ports, a pull-up on every line
// assumes: the bench picks which released lines an outside source drives
`timescale 1ns/1ps
`default_nettype none
module pdr_field_model (
  input  wire pdr_pkg::pdr_lines_t [3:0] line_out,
  input  wire pdr_pkg::pdr_lines_t [3:0] line_oe_n,
  input  wire logic [95:0]               ext_en,
  input  wire logic [95:0]               ext_val,
  output logic [95:0]                    pin
);
  // released line floats to the pull-up unless a source drives it
  assign pin = (~line_oe_n & line_out) | (line_oe_n & (~ext_en | ext_val));
endmodule : pdr_field_model
`default_nettype wire

// [verification/tb_top.sv]
// tb_top: directed tests of strap direction and reset retention over AHB-Lite
// assumes: single slave, hreadyout fed back as hready, direction straps fixed for the run, retention strap raised midway
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [15:0] STRAPS = 16'ha410;
  logic                      hclk, hresetn, por_n, hsel, hwrite, hreadyout, hresp, retain;
  logic [1:0]                htrans;
  logic [31:0]               haddr, hwdata, hrdata, rd;
  logic [95:0]               ext_en, ext_val, pin, exp_oe, exp_pin;
  pdr_pkg::pdr_lines_t [3:0] line_out, line_oe_n;
  logic [3:0]                sw_dir [4];
  logic [23:0]               out_val [4];
  int                        num_errors, check_count;

  pdr_port_ctl dut (.hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .reset_retain_strap(retain),
    .dir_strap(STRAPS), .line_in(pin), .line_out(line_out), .line_oe_n(line_oe_n));
  pdr_field_model field (.line_out(line_out), .line_oe_n(line_oe_n), .ext_en(ext_en),
    .ext_val(ext_val), .pin(pin));

  always #4 hclk = ~hclk;

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected register at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pins(input logic [95:0] got, input logic [95:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected pins at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_pins

  // waits are bounded so a stuck slave shows up as a mismatch, not a hang
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    chk_reg({31'h0, hreadyout}, 32'h0000_0001);
    chk_reg({31'h0, hresp}, 32'h0000_0000);
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  function automatic logic [31:0] cw_of(input logic [3:0] d);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[pdr_pkg::CW_PORTA_BIT] = d[pdr_pkg::DIR_A];
    w[pdr_pkg::CW_CHI_BIT] = d[pdr_pkg::DIR_CH];
    w[pdr_pkg::CW_PORTB_BIT] = d[pdr_pkg::DIR_B];
    w[pdr_pkg::CW_CLO_BIT] = d[pdr_pkg::DIR_CL];
    return w;
  endfunction : cw_of

  function automatic logic [23:0] oe_of(input logic [3:0] d);
    return {{4{d[pdr_pkg::DIR_CH]}}, {4{d[pdr_pkg::DIR_CL]}},
            {8{d[pdr_pkg::DIR_B]}}, {8{d[pdr_pkg::DIR_A]}}};
  endfunction : oe_of

  task automatic set_dir(input int g, input logic [3:0] d);
    sw_dir[g] = d;
    bus(1'b1, 8'(4 * g + 3), cw_of(d));
  endtask : set_dir

  task automatic set_out(input int g, input logic [23:0] v);
    out_val[g] = v;
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, 8'(4 * g + k), {24'h0, v[8 * k +: 8]});
    end
  endtask : set_out

  // strapped bits must read as output whatever software wrote
  task automatic check_all();
    logic [3:0] d;
    for (int g = 0; g < 4; g++) begin
      d = sw_dir[g] & ~STRAPS[4 * g +: 4];
      bus(1'b0, 8'(4 * g + 3), 32'h0000_0000);
      chk_reg(rd & 32'h0000_001b, cw_of(d));
      exp_oe[24 * g +: 24] = oe_of(d);
      exp_pin[24 * g +: 24] = oe_of(d) | out_val[g];
      for (int k = 0; k < 3; k++) begin
        bus(1'b0, 8'(4 * g + k), 32'h0000_0000);
        chk_reg(rd & 32'h0000_00ff, {24'h0, exp_pin[24 * g + 8 * k +: 8]});
      end
    end
    chk_pins(line_oe_n, exp_oe);
    chk_pins(pin, exp_pin);
  endtask : check_all

  task automatic do_reset(input logic power);
    hresetn <= 1'b0;
    por_n <= ~power;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
    repeat (6) @(posedge hclk);
    if (power || !retain) begin
      for (int g = 0; g < 4; g++) begin
        sw_dir[g] = 4'hf;
        out_val[g] = 24'h00_0000;
      end
    end
  endtask : do_reset

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  initial begin
    #100000;
    num_errors++;
    summarize();
  end

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    por_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    retain = 1'b0;
    ext_en = '0;
    ext_val = '0;
    do_reset(1'b1);
    check_all();
    bus(1'b0, 8'h10, 32'h0000_0000);
    chk_reg(rd & 32'h0001_ffff, {15'h0, retain, STRAPS});
    bus(1'b1, 8'h11, 32'hffff_ffff);
    bus(1'b0, 8'h11, 32'h0000_0000);
    chk_reg(rd, 32'h0000_0000);
    $display("test power_on done");
    for (int g = 0; g < 4; g++) begin
      set_dir(g, 4'h0);
      set_out(g, 24'h5a_c381 ^ 24'(g * 24'h11_1111));
    end
    check_all();
    set_dir(1, 4'hf);
    set_dir(0, 4'h5);
    ext_en[7:0] <= 8'hff;
    ext_val[7:0] <= 8'h3c;
    repeat (4) @(posedge hclk);
    bus(1'b0, 8'h00, 32'h0000_0000);
    chk_reg(rd & 32'h0000_00ff, 32'h0000_003c);
    ext_en <= '0;
    repeat (4) @(posedge hclk);
    check_all();
    $display("test software_direction done");
    do_reset(1'b0);
    check_all();
    $display("test hot_reset_plain done");
    retain <= 1'b1;
    repeat (4) @(posedge hclk);
    for (int g = 0; g < 4; g++) begin
      set_dir(g, 4'h6 ^ 4'(g));
      set_out(g, 24'hf0_96a5 ^ 24'(g));
    end
    do_reset(1'b0);
    check_all();
    bus(1'b0, 8'h10, 32'h0000_0000);
    chk_reg(rd & 32'h0003_0000, 32'h0003_0000);
    $display("test hot_reset_retained done");
    do_reset(1'b1);
    check_all();
    $display("test power_loss done");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
